// ===== rtl/twb_pkg.sv
package twb_pkg;

  // ==========================================================================
  // Word framing
  // ==========================================================================
  localparam int          WORD_BITS     = 8;
  localparam logic [3:0]  BIT_CNT_WORD  = 4'h8;
  localparam logic [3:0]  RECOV_PULSES  = 4'h9;
  localparam logic [3:0]  DEV_TYPE_CODE = 4'hA;
  localparam int          SEL_W         = 3;

  // ==========================================================================
  // Master commands
  // ==========================================================================
  localparam logic [2:0]  CMD_START     = 3'h1;
  localparam logic [2:0]  CMD_WRITE     = 3'h2;
  localparam logic [2:0]  CMD_READ      = 3'h3;
  localparam logic [2:0]  CMD_STOP      = 3'h4;
  localparam logic [2:0]  CMD_RECOVER   = 3'h5;

  // ==========================================================================
  // Timing of the generated serial clock
  // ==========================================================================
  localparam int          CLK_NS        = 10;
  localparam int          SCL_LOW_NS    = 1300;
  localparam int          SCL_HIGH_NS   = 1200;
  localparam int          BUF_NS        = 1300;
  localparam int          TMR_W         = 8;
  localparam logic [7:0]  LOW_CYC       =
    8'((SCL_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  HALF_LOW_CYC  =
    8'((SCL_LOW_NS + 2 * CLK_NS - 1) / (2 * CLK_NS));
  localparam logic [7:0]  HIGH_CYC      =
    8'((SCL_HIGH_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0]  BUF_CYC       =
    8'((BUF_NS + CLK_NS - 1) / CLK_NS);

endpackage

// ===== rtl/twb_if.sv
`timescale 1ns/10ps
interface twb_if;

  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic scl;
  logic sda;

  // Both lines are pulled high; any enabled driver with a low value wins.
  assign scl = !(scl_m_oe && !scl_m_o);
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_d_oe && !sda_d_o));

  modport master (
    output scl_m_o,
    output scl_m_oe,
    output sda_m_o,
    output sda_m_oe,
    input  scl,
    input  sda
  );

  modport target (
    output sda_d_o,
    output sda_d_oe,
    input  scl,
    input  sda
  );

endinterface

// ===== rtl/bus_master.sv
`timescale 1ns/10ps
module bus_master (
  input  wire logic                   mclk_i,
  input  wire logic                   rstn_i,
  twb_if.master                       bus,
  input  wire logic                   cmd_valid_i,
  input  wire logic [2:0]             cmd_op_i,
  input  wire logic [7:0]             cmd_data_i,
  input  wire logic                   cmd_ack_i,
  output logic                        cmd_ready_o,
  output logic                        done_o,
  output logic [7:0]                  rd_data_o,
  output logic                        nack_o
);
  import twb_pkg::*;

  typedef enum logic [12:0] {
    M_IDLE = 13'h0001,
    M_SA   = 13'h0002,
    M_SB   = 13'h0004,
    M_SC   = 13'h0008,
    M_BL   = 13'h0010,
    M_BS   = 13'h0020,
    M_BH   = 13'h0040,
    M_PA   = 13'h0080,
    M_PB   = 13'h0100,
    M_PC   = 13'h0200,
    M_WT   = 13'h0400,
    M_RL   = 13'h0800,
    M_RH   = 13'h1000
  } mstate_t;

  // ==========================================================================
  // Data line synchroniser
  // ==========================================================================
  logic sda_meta_reg;
  logic sda_sync_reg;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
    end else begin
      sda_meta_reg <= bus.sda;
      sda_sync_reg <= sda_meta_reg;
    end
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  mstate_t          state_reg,  state_next;
  logic [TMR_W-1:0] tmr_reg,    tmr_next;
  logic [3:0]       cnt_reg,    cnt_next;
  logic [8:0]       tx_reg,     tx_next;
  logic [8:0]       rx_reg,     rx_next;
  logic             scl_oe_reg, scl_oe_next;
  logic             sda_oe_reg, sda_oe_next;
  logic             done_reg,   done_next;
  logic [7:0]       rd_reg,     rd_next;
  logic             nack_reg,   nack_next;

  always_comb begin
    state_next  = state_reg;
    tmr_next    = tmr_reg;
    cnt_next    = cnt_reg;
    tx_next     = tx_reg;
    rx_next     = rx_reg;
    scl_oe_next = scl_oe_reg;
    sda_oe_next = sda_oe_reg;
    done_next   = 1'b0;
    rd_next     = rd_reg;
    nack_next   = nack_reg;
    if (state_reg != M_IDLE && tmr_reg != '0) begin
      tmr_next = tmr_reg - 8'h01;
    end else begin
      case (state_reg)
        M_IDLE: begin
          if (cmd_valid_i) begin
            case (cmd_op_i)
              CMD_START: begin
                scl_oe_next = 1'b1;
                sda_oe_next = 1'b0;
                tmr_next    = LOW_CYC;
                state_next  = M_SA;
              end
              CMD_WRITE, CMD_READ: begin
                // Nine clocks per word: eight data bits, then acknowledge.
                tx_next     = (cmd_op_i == CMD_WRITE) ? {cmd_data_i, 1'b1}
                                                      : {8'hFF, !cmd_ack_i};
                cnt_next    = 4'h0;
                scl_oe_next = 1'b1;
                tmr_next    = HALF_LOW_CYC;
                state_next  = M_BL;
              end
              CMD_STOP: begin
                scl_oe_next = 1'b1;
                tmr_next    = HALF_LOW_CYC;
                state_next  = M_PA;
              end
              CMD_RECOVER: begin
                scl_oe_next = 1'b1;
                sda_oe_next = 1'b0;
                cnt_next    = 4'h0;
                tmr_next    = LOW_CYC;
                state_next  = M_RL;
              end
              default: begin
                done_next = 1'b1;
              end
            endcase
          end
        end
        M_SA: begin
          scl_oe_next = 1'b0;
          tmr_next    = HIGH_CYC;
          state_next  = M_SB;
        end
        M_SB: begin
          sda_oe_next = 1'b1;
          tmr_next    = HIGH_CYC;
          state_next  = M_SC;
        end
        M_SC: begin
          scl_oe_next = 1'b1;
          done_next   = 1'b1;
          state_next  = M_IDLE;
        end
        M_BL: begin
          // Data moves only in the middle of the low phase.
          sda_oe_next = !tx_reg[8];
          tmr_next    = HALF_LOW_CYC;
          state_next  = M_BS;
        end
        M_BS: begin
          scl_oe_next = 1'b0;
          tmr_next    = HIGH_CYC;
          state_next  = M_BH;
        end
        M_BH: begin
          rx_next     = {rx_reg[7:0], sda_sync_reg};
          tx_next     = {tx_reg[7:0], 1'b1};
          cnt_next    = cnt_reg + 4'h1;
          scl_oe_next = 1'b1;
          tmr_next    = HALF_LOW_CYC;
          if (cnt_reg == BIT_CNT_WORD) begin
            rd_next    = rx_reg[7:0];
            nack_next  = sda_sync_reg;
            done_next  = 1'b1;
            tmr_next   = '0;
            state_next = M_IDLE;
          end else begin
            state_next = M_BL;
          end
        end
        M_PA: begin
          sda_oe_next = 1'b1;
          tmr_next    = HALF_LOW_CYC;
          state_next  = M_PB;
        end
        M_PB: begin
          scl_oe_next = 1'b0;
          tmr_next    = HIGH_CYC;
          state_next  = M_PC;
        end
        M_PC: begin
          sda_oe_next = 1'b0;
          tmr_next    = BUF_CYC;
          state_next  = M_WT;
        end
        M_WT: begin
          done_next  = 1'b1;
          state_next = M_IDLE;
        end
        M_RL: begin
          scl_oe_next = 1'b0;
          tmr_next    = HIGH_CYC;
          state_next  = M_RH;
        end
        M_RH: begin
          // A free data line ends the pulses early; a start follows.
          cnt_next    = cnt_reg + 4'h1;
          scl_oe_next = 1'b1;
          tmr_next    = LOW_CYC;
          if (sda_sync_reg || cnt_next == RECOV_PULSES) begin
            state_next = M_SA;
          end else begin
            state_next = M_RL;
          end
        end
        default: begin
          state_next = M_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      state_reg  <= M_IDLE;
      tmr_reg    <= '0;
      cnt_reg    <= 4'h0;
      tx_reg     <= 9'h1FF;
      rx_reg     <= 9'h000;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      done_reg   <= 1'b0;
      rd_reg     <= 8'h00;
      nack_reg   <= 1'b0;
    end else begin
      state_reg  <= state_next;
      tmr_reg    <= tmr_next;
      cnt_reg    <= cnt_next;
      tx_reg     <= tx_next;
      rx_reg     <= rx_next;
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
      done_reg   <= done_next;
      rd_reg     <= rd_next;
      nack_reg   <= nack_next;
    end
  end

  assign bus.scl_m_o  = 1'b0;
  assign bus.sda_m_o  = 1'b0;
  assign bus.scl_m_oe = scl_oe_reg;
  assign bus.sda_m_oe = sda_oe_reg;
  assign cmd_ready_o  = (state_reg == M_IDLE);
  assign done_o       = done_reg;
  assign rd_data_o    = rd_reg;
  assign nack_o       = nack_reg;

endmodule

// ===== rtl/eeprom_target.sv
// Functional notes
// - Sender changes data only while clock low.
// - Data edge during clock high is condition.
// - Falling data, clock high: start, new transaction.
// - Rising data, clock high: stop, transaction ends.
// - Stop after read enters standby.
// - Words are eight bits plus acknowledge clock.
// - Device pulls data low on ninth clock.
// - Standby at power-up and after stop, idle.
// - Master recovers bus: up to nine pulses, then start.
// - Sample on rising clock, launch on falling.
// - First word after start is device address.
`timescale 1ns/10ps
module eeprom_target (
  input  wire logic                   mclk_i,
  input  wire logic                   rstn_i,
  twb_if.target                       bus,
  input  wire logic [twb_pkg::SEL_W-1:0] dev_sel_i,
  input  wire logic                   busy_i,
  input  wire logic [7:0]             tx_data_i,
  output logic                        tx_load_o,
  output logic [7:0]                  rx_data_o,
  output logic                        rx_valid_o,
  output logic                        rx_addr_o,
  output logic                        read_o,
  output logic                        start_o,
  output logic                        stop_o,
  output logic                        standby_o
);
  import twb_pkg::*;

  typedef enum logic [6:0] {
    ST_IDLE   = 7'h01,
    ST_ADDR   = 7'h02,
    ST_RX     = 7'h04,
    ST_ACK    = 7'h08,
    ST_TX     = 7'h10,
    ST_MACK   = 7'h20,
    ST_IGNORE = 7'h40
  } tstate_t;

  // ==========================================================================
  // Line synchronisers and edge detection
  // ==========================================================================
  // The serial lines come from outside this clock, so each passes two
  // flip-flops; a third stage holds the previous level for edge finding.
  logic scl_meta_reg;
  logic scl_sync_reg;
  logic scl_prev_reg;
  logic sda_meta_reg;
  logic sda_sync_reg;
  logic sda_prev_reg;

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_meta_reg <= bus.scl;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= bus.sda;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  assign scl_rise  = scl_sync_reg && !scl_prev_reg;
  assign scl_fall  = !scl_sync_reg && scl_prev_reg;
  // Both clock samples must be high, so a data change that lands on the
  // same sample as a clock edge is never taken for a condition.
  assign start_det = scl_sync_reg && scl_prev_reg &&
                     sda_prev_reg && !sda_sync_reg;
  assign stop_det  = scl_sync_reg && scl_prev_reg &&
                     !sda_prev_reg && sda_sync_reg;

  // ==========================================================================
  // Word engine
  // ==========================================================================
  tstate_t    state_reg,   state_next;
  logic [3:0] cnt_reg,     cnt_next;
  logic [7:0] sh_reg,      sh_next;
  logic       oe_reg,      oe_next;
  logic       read_reg,    read_next;
  logic [7:0] rxd_reg,     rxd_next;
  logic       rxv_reg,     rxv_next;
  logic       rxa_reg,     rxa_next;
  logic       load_reg,    load_next;
  logic       start_reg,   start_next;
  logic       stop_reg,    stop_next;
  logic       stby_reg,    stby_next;
  logic       pend_reg,    pend_next;
  logic       addr_match;

  assign addr_match = (sh_reg[7:4] == DEV_TYPE_CODE) &&
                      (sh_reg[3:1] == dev_sel_i);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    sh_next    = sh_reg;
    oe_next    = oe_reg;
    read_next  = read_reg;
    rxd_next   = rxd_reg;
    rxv_next   = 1'b0;
    rxa_next   = rxa_reg;
    load_next  = 1'b0;
    start_next = 1'b0;
    stop_next  = 1'b0;
    stby_next  = stby_reg;
    pend_next  = pend_reg;
    if (start_det) begin
      // A start aborts whatever was going on and wakes the device.
      state_next = ST_ADDR;
      cnt_next   = 4'h0;
      oe_next    = 1'b0;
      read_next  = 1'b0;
      start_next = 1'b1;
      stby_next  = 1'b0;
      pend_next  = 1'b0;
    end else begin
      if (stop_det) begin
        state_next = ST_IDLE;
        oe_next    = 1'b0;
        stop_next  = 1'b1;
        pend_next  = 1'b1;
      end else begin
        case (state_reg)
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              sh_next  = {sh_reg[6:0], sda_sync_reg};
              cnt_next = cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == BIT_CNT_WORD) begin
              if (state_reg == ST_ADDR && !addr_match) begin
                // Not addressed: stay off the line until the next start.
                state_next = ST_IGNORE;
              end else begin
                oe_next    = 1'b1;
                state_next = ST_ACK;
                rxd_next   = sh_reg;
                rxv_next   = 1'b1;
                rxa_next   = (state_reg == ST_ADDR);
                if (state_reg == ST_ADDR) begin
                  read_next = sh_reg[0];
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              cnt_next = 4'h0;
              if (read_reg) begin
                sh_next    = tx_data_i;
                oe_next    = !tx_data_i[7];
                load_next  = 1'b1;
                state_next = ST_TX;
              end else begin
                oe_next    = 1'b0;
                state_next = ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              cnt_next = cnt_reg + 4'h1;
            end else if (scl_fall) begin
              if (cnt_reg == BIT_CNT_WORD) begin
                oe_next    = 1'b0;
                state_next = ST_MACK;
              end else begin
                sh_next = {sh_reg[6:0], 1'b1};
                oe_next = !sh_reg[6];
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              // A released line on the ninth clock ends the read burst.
              if (sda_sync_reg) begin
                state_next = ST_IGNORE;
              end
            end else if (scl_fall) begin
              cnt_next   = 4'h0;
              sh_next    = tx_data_i;
              oe_next    = !tx_data_i[7];
              load_next  = 1'b1;
              state_next = ST_TX;
            end
          end
          ST_IDLE, ST_IGNORE: begin
            oe_next = 1'b0;
          end
          default: begin
            state_next = ST_IDLE;
            oe_next    = 1'b0;
          end
        endcase
      end
      // Standby waits for the user side to finish any internal operation.
      if (pend_next && !busy_i) begin
        stby_next = 1'b1;
        pend_next = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 4'h0;
      sh_reg    <= 8'hFF;
      oe_reg    <= 1'b0;
      read_reg  <= 1'b0;
      rxd_reg   <= 8'h00;
      rxv_reg   <= 1'b0;
      rxa_reg   <= 1'b0;
      load_reg  <= 1'b0;
      start_reg <= 1'b0;
      stop_reg  <= 1'b0;
      stby_reg  <= 1'b1;
      pend_reg  <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      sh_reg    <= sh_next;
      oe_reg    <= oe_next;
      read_reg  <= read_next;
      rxd_reg   <= rxd_next;
      rxv_reg   <= rxv_next;
      rxa_reg   <= rxa_next;
      load_reg  <= load_next;
      start_reg <= start_next;
      stop_reg  <= stop_next;
      stby_reg  <= stby_next;
      pend_reg  <= pend_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // The pad only ever pulls low; a high bit is sent by letting go.
  assign bus.sda_d_o  = 1'b0;
  assign bus.sda_d_oe = oe_reg;
  assign tx_load_o    = load_reg;
  assign rx_data_o    = rxd_reg;
  assign rx_valid_o   = rxv_reg;
  assign rx_addr_o    = rxa_reg;
  assign read_o       = read_reg;
  assign start_o      = start_reg;
  assign stop_o       = stop_reg;
  assign standby_o    = stby_reg;

endmodule

// ===== verification/two_wire_eeprom_bus_protocol_chk.sv
`timescale 1ns/10ps
module twb_chk #(
  parameter logic [twb_pkg::SEL_W-1:0] DEV_SEL = 3'h5
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic scl_m_o,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_d_o,
  input wire logic sda_d_oe,
  input wire logic scl,
  input wire logic sda
);
  import twb_pkg::*;

  // ==========
  // Wire tracker
  // ==========
  typedef struct packed {
    logic       first;
    logic       rd;
    logic       match;
    logic [3:0] cnt;
    logic [7:0] shift;
  } trk_t;

  trk_t trk_reg, trk_next;
  logic scl_q_reg, scl_q_next, sda_q_reg, sda_q_next;
  logic rise, start, stop, addr_ok, ack_slot;

  assign rise     = scl && !scl_q_reg;
  assign start    = scl && scl_q_reg && sda_q_reg && !sda;
  assign stop     = scl && scl_q_reg && !sda_q_reg && sda;
  assign ack_slot = rise && (trk_reg.cnt == BIT_CNT_WORD);
  assign addr_ok  = (trk_reg.shift[7:4] == DEV_TYPE_CODE) &&
                    (trk_reg.shift[3:1] == DEV_SEL);

  always_comb begin
    scl_q_next = scl;
    sda_q_next = sda;
    trk_next   = trk_reg;
    if (start || stop) begin
      trk_next.cnt   = 4'h0;
      trk_next.first = start;
      trk_next.match = 1'b0;
    end else if (ack_slot) begin
      trk_next.cnt   = 4'h0;
      trk_next.first = 1'b0;
      if (trk_reg.first) begin
        trk_next.rd    = trk_reg.shift[0];
        trk_next.match = addr_ok;
      end else if (trk_reg.rd && sda) begin
        // A refused read byte silences the target until the next condition.
        trk_next.match = 1'b0;
      end
    end else if (rise) begin
      trk_next.cnt   = trk_reg.cnt + 4'h1;
      trk_next.shift = {trk_reg.shift[6:0], sda};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      trk_reg   <= '0;
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      trk_reg   <= trk_next;
      scl_q_reg <= scl_q_next;
      sda_q_reg <= sda_q_next;
    end
  end

  // ==========
  // Assertions
  // ==========
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  drive_low_a: assert property (
    !scl_m_o && !sda_m_o && !sda_d_o) else $error("line driven high");
  edge_launch_a: assert property (
    $changed(sda_d_oe) |-> !scl && !scl_q_reg)
    else $error("target moved data while clock high");
  cond_owner_a: assert property (
    scl && scl_q_reg && (sda != sda_q_reg) |-> $changed(sda_m_oe))
    else $error("data edge in clock high not made by master");
  ack_a: assert property (
    ack_slot && (trk_reg.first ? addr_ok : trk_reg.match && !trk_reg.rd)
    |-> sda_d_oe && !sda) else $error("missing acknowledge");
  no_ack_a: assert property (
    ack_slot && trk_reg.first && !addr_ok |-> !sda_d_oe)
    else $error("foreign address acknowledged");
  idle_release_a: assert property (
    rise && sda_d_oe && !(trk_reg.match && trk_reg.rd && !trk_reg.first)
    |-> trk_reg.cnt == BIT_CNT_WORD) else $error("data held outside ack");
  read_slot_a: assert property (
    ack_slot && trk_reg.rd && trk_reg.match && !trk_reg.first |-> !sda_d_oe)
    else $error("target drove master ack slot");
  cond_release_a: assert property (
    start || stop |-> ##1 (!sda_d_oe) [*8])
    else $error("target drove data after condition");

  cover property (ack_slot && trk_reg.first && addr_ok);
  cover property (rise && sda_d_oe && trk_reg.rd && !trk_reg.first);
  cover property (start && trk_reg.cnt == 4'h0 && !trk_reg.first);
  cover property (stop);
endmodule

// ===== verification/two_wire_eeprom_bus_protocol_tb.sv
`timescale 1ns/10ps
module two_wire_eeprom_bus_protocol_tb;
  import twb_pkg::*;
  localparam logic [SEL_W-1:0] DSEL = 3'h5;
  localparam logic [7:0] ADDR_WR = {DEV_TYPE_CODE, DSEL, 1'b0};
  localparam logic [7:0] ADDR_RD = {DEV_TYPE_CODE, DSEL, 1'b1};

  logic       mclk_i, rstn_i, cmd_valid_i, cmd_ack_i, busy_i;
  logic [2:0] cmd_op_i;
  logic [7:0] cmd_data_i, tx_data_i, rd_data_o, rx_data_o;
  logic       cmd_ready_o, done_o, nack_o, tx_load_o, rx_valid_o;
  logic       rx_addr_o, read_o, start_o, stop_o, standby_o;
  int         bad_count = 0, compares = 0;
  int         n_start = 0, n_stop = 0, n_rx = 0, n_load = 0;

  twb_if twb_if_inst ();
  bus_master bus_master_inst (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .bus(twb_if_inst.master), .cmd_valid_i(cmd_valid_i),
    .cmd_op_i(cmd_op_i), .cmd_data_i(cmd_data_i), .cmd_ack_i(cmd_ack_i),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .rd_data_o(rd_data_o),
    .nack_o(nack_o));
  eeprom_target eeprom_target_inst (.mclk_i(mclk_i), .rstn_i(rstn_i),
    .bus(twb_if_inst.target), .dev_sel_i(DSEL), .busy_i(busy_i),
    .tx_data_i(tx_data_i), .tx_load_o(tx_load_o), .rx_data_o(rx_data_o),
    .rx_valid_o(rx_valid_o), .rx_addr_o(rx_addr_o), .read_o(read_o),
    .start_o(start_o), .stop_o(stop_o), .standby_o(standby_o));
  twb_chk #(.DEV_SEL(DSEL)) twb_chk_inst (.mclk_i(mclk_i),
    .rstn_i(rstn_i), .scl_m_o(twb_if_inst.scl_m_o),
    .sda_m_o(twb_if_inst.sda_m_o), .sda_m_oe(twb_if_inst.sda_m_oe),
    .sda_d_o(twb_if_inst.sda_d_o), .sda_d_oe(twb_if_inst.sda_d_oe),
    .scl(twb_if_inst.scl), .sda(twb_if_inst.sda));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  always @(posedge mclk_i) begin
    if (start_o === 1'b1) n_start++;
    if (stop_o === 1'b1) n_stop++;
    if (rx_valid_o === 1'b1) n_rx++;
    if (tx_load_o === 1'b1) n_load++;
  end

  // ==========
  // Helpers
  // ==========
  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  // Every command leaves the bench one step after a clock edge.
  task automatic cmd(input logic [2:0] op, input logic [7:0] d,
                     input logic ack);
    int n;
    n = 0;
    @(posedge mclk_i);
    #1;
    cmd_op_i = op;
    cmd_data_i = d;
    cmd_ack_i = ack;
    cmd_valid_i = 1'b1;
    chk(cmd_ready_o === 1'b1, "not ready for command");
    @(posedge mclk_i);
    #1;
    cmd_valid_i = 1'b0;
    // A known command keeps the sequencer busy; an unknown one is a no-op.
    chk(cmd_ready_o === !(op inside {[CMD_START:CMD_RECOVER]}),
        "ready level after take");
    while (done_o !== 1'b1 && n < 4000) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    chk(n < 4000, "command hang");
  endtask

  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ==========
  // Scenarios
  // ==========
  task automatic t_reset;
    int s0;
    chk(standby_o === 1'b1, "no standby at reset");
    chk(twb_if_inst.sda === 1'b1, "data not released");
    s0 = n_start;
    cmd(3'h7, 8'h00, 1'b0);
    chk(n_start == s0 && twb_if_inst.scl === 1'b1 && standby_o === 1'b1,
        "no-op disturbed the bus");
    $display("test reset done");
  endtask

  task automatic t_write;
    int s0, p0, r0;
    s0 = n_start;
    p0 = n_stop;
    r0 = n_rx;
    cmd(CMD_START, 8'h00, 1'b0);
    chk(n_start == s0 + 1 && standby_o === 1'b0, "start missed");
    cmd(CMD_WRITE, ADDR_WR, 1'b0);
    chk(nack_o === 1'b0 && rx_addr_o === 1'b1, "address refused");
    chk(read_o === 1'b0, "direction wrong");
    cmd(CMD_WRITE, 8'hA5, 1'b0);
    chk(nack_o === 1'b0 && rx_data_o === 8'hA5, "data word");
    chk(n_rx == r0 + 2, "word count");
    busy_i = 1'b1;
    cmd(CMD_STOP, 8'h00, 1'b0);
    chk(n_stop == p0 + 1 && standby_o === 1'b0, "standby too early");
    busy_i = 1'b0;
    repeat (3) @(posedge mclk_i);
    #1;
    chk(standby_o === 1'b1, "standby after stop");
    $display("test write done");
  endtask

  task automatic t_read;
    int s0, l0;
    s0 = n_start;
    cmd(CMD_START, 8'h00, 1'b0);
    cmd(CMD_WRITE, ADDR_WR, 1'b0);
    cmd(CMD_WRITE, 8'h10, 1'b0);
    tx_data_i = 8'hC3;
    l0 = n_load;
    cmd(CMD_START, 8'h00, 1'b0);
    chk(n_start == s0 + 2, "repeated start");
    cmd(CMD_WRITE, ADDR_RD, 1'b0);
    chk(nack_o === 1'b0 && read_o === 1'b1, "read address");
    cmd(CMD_READ, 8'h00, 1'b1);
    chk(rd_data_o === 8'hC3 && n_load == l0 + 1, "first byte");
    tx_data_i = 8'h3C;
    cmd(CMD_READ, 8'h00, 1'b0);
    chk(rd_data_o === 8'h3C, "second byte");
    cmd(CMD_STOP, 8'h00, 1'b0);
    chk(standby_o === 1'b1, "standby after read");
    $display("test read done");
  endtask

  task automatic t_bad_addr;
    logic [7:0] bad [2];
    bad = '{{DEV_TYPE_CODE, ~DSEL, 1'b0}, {4'h5, DSEL, 1'b0}};
    for (int i = 0; i < 2; i++) begin
      cmd(CMD_START, 8'h00, 1'b0);
      cmd(CMD_WRITE, bad[i], 1'b0);
      chk(nack_o === 1'b1, "foreign address acked");
      cmd(CMD_WRITE, 8'h00, 1'b0);
      chk(nack_o === 1'b1, "ignored word acked");
      cmd(CMD_STOP, 8'h00, 1'b0);
    end
    $display("test bad address done");
  endtask

  // The target is left mid-read driving zeros, so recovery must clock it out.
  task automatic t_recover;
    int s0;
    tx_data_i = 8'h00;
    cmd(CMD_START, 8'h00, 1'b0);
    cmd(CMD_WRITE, ADDR_RD, 1'b0);
    cmd(CMD_READ, 8'h00, 1'b1);
    chk(rd_data_o === 8'h00, "zero byte");
    s0 = n_start;
    cmd(CMD_RECOVER, 8'h00, 1'b0);
    chk(n_start == s0 + 1, "recovery start");
    cmd(CMD_WRITE, ADDR_WR, 1'b0);
    chk(nack_o === 1'b0, "no answer after recovery");
    cmd(CMD_STOP, 8'h00, 1'b0);
    $display("test recover done");
  endtask

  initial begin
    rstn_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_op_i = 3'h0;
    cmd_data_i = 8'h00;
    cmd_ack_i = 1'b0;
    busy_i = 1'b0;
    tx_data_i = 8'h00;
    repeat (10) @(posedge mclk_i);
    #1;
    rstn_i = 1'b1;
    t_reset;
    t_write;
    t_read;
    t_bad_addr;
    t_recover;
    finish_test;
  end

  initial begin
    repeat (90000) @(posedge mclk_i);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test;
  end
endmodule
